//--- logic/sfa_pkg.sv
package sfa_pkg;
    // ==========================================================
    // Register map, byte addresses on the bus
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADDR_CONTROL = 8'h00;
    localparam logic [ADR_W-1:0] ADDR_COMMAND = 8'h04;
    localparam logic [ADR_W-1:0] ADDR_REPEAT  = 8'h08;
    localparam logic [ADR_W-1:0] ADDR_ACCUM   = 8'h0C;
    localparam logic [ADR_W-1:0] ADDR_OPERAND = 8'h10;
    localparam logic [ADR_W-1:0] ADDR_STATUS  = 8'h14;
    localparam logic [ADR_W-1:0] ADDR_TALLY   = 8'h18;

    // ==========================================================
    // Field positions
    localparam int SAT_BIT      = 0;
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_HALF_BIT = 4;
    localparam int BUSY_BIT     = 8;
    localparam int ARMED_BIT    = 16;
    localparam int FLAG_W       = 4;

    // ==========================================================
    // Operation codes
    localparam logic [1:0] OP_LONG  = 2'h0;
    localparam logic [1:0] OP_REV16 = 2'h1;
    localparam logic [1:0] OP_REV32 = 2'h2;
    localparam logic [1:0] OP_UNS16 = 2'h3;

    // ==========================================================
    // Limits and reset values
    localparam logic [31:0] MAX_POS_32  = 32'h7FFFFFFF;
    localparam logic [31:0] MAX_NEG_32  = 32'h80000000;
    localparam logic [31:0] ACCUM_RST   = 32'h00000000;
    localparam logic [31:0] OPERAND_RST = 32'h00000000;
    localparam logic        SAT_RST     = 1'b0;

    // ==========================================================
    // Types
    typedef struct packed {
        logic v;
        logic c;
        logic n;
        logic z;
    } sfa_flags_type;

    typedef struct packed {
        logic [1:0] op;
        logic       hi;
    } sfa_cmd_type;

    typedef enum logic [1:0] {
        SFA_IDLE = 2'b01,
        SFA_EXEC = 2'b10
    } sfa_state_type;

    localparam sfa_flags_type FLAGS_RST = '{v: 1'b0, c: 1'b0, n: 1'b0, z: 1'b0};
    localparam sfa_cmd_type   CMD_RST   = '{op: 2'h0, hi: 1'b0};
endpackage

//--- logic/sfa_sub_core.sv
module sfa_sub_core #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] a_in,
    input  wire logic [W-1:0] b_in,
    output logic      [W-1:0] diff_out,
    output logic              borrow_out,
    output logic              ov_pos_out,
    output logic              ov_neg_out
);
    logic [W:0] wide;

    // Extra top bit of the unsigned difference is the borrow
    assign wide       = {1'b0, a_in} - {1'b0, b_in};
    assign diff_out   = wide[W-1:0];
    assign borrow_out = wide[W];
    assign ov_pos_out = !a_in[W-1] && b_in[W-1] && diff_out[W-1];
    assign ov_neg_out = a_in[W-1] && !b_in[W-1] && !diff_out[W-1];
endmodule

//--- logic/sfa_repeat_ctl.sv
module sfa_repeat_ctl #(
    parameter int CW = 8
) (
    input  wire logic          sys_clk_in,
    input  wire logic          srst_in,
    input  wire logic          clk_en_in,
    input  wire logic          load_in,
    input  wire logic [CW-1:0] load_val_in,
    input  wire logic          start_in,
    input  wire logic          repeatable_in,
    input  wire logic          step_in,
    output logic      [CW-1:0] count_out,
    output logic               armed_out,
    output logic               last_out
);
    logic [CW-1:0] count_reg;
    logic          armed_reg;

    // ==========================================================
    // Repeat counter
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            count_reg <= '0;
        end else if (clk_en_in) begin
            if (load_in) begin
                count_reg <= load_val_in;
            end else if (start_in && !(repeatable_in && armed_reg)) begin
                count_reg <= '0;
            end else if (step_in && count_reg != '0) begin
                count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Prefix is consumed by the next command of any kind
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            armed_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (load_in) begin
                armed_reg <= 1'b1;
            end else if (start_in) begin
                armed_reg <= 1'b0;
            end
        end
    end

    assign count_out = count_reg;
    assign armed_out = armed_reg;
    assign last_out  = count_reg == '0;
endmodule

//--- logic/sfa_alu.sv
// The Wishbone interface to the registers and the placing of the registers were decided locally.
module sfa_alu #(
    parameter int RPT_W   = 8,
    parameter int TALLY_W = 8
) (
    input  wire logic                       sys_clk_in,
    input  wire logic                       srst_in,
    input  wire logic                       clk_en_in,
    input  wire logic                       wb_cyc_in,
    input  wire logic                       wb_stb_in,
    input  wire logic                       wb_we_in,
    input  wire logic [sfa_pkg::ADR_W-1:0]  wb_adr_in,
    input  wire logic [3:0]                 wb_sel_in,
    input  wire logic [31:0]                wb_dat_in,
    output logic      [31:0]                wb_dat_out,
    output logic                            wb_ack_out,
    output logic                            busy_out,
    output logic      [31:0]                result_out,
    output sfa_pkg::sfa_flags_type          flags_out
);
    sfa_pkg::sfa_state_type state_reg;
    sfa_pkg::sfa_state_type state_next;
    sfa_pkg::sfa_cmd_type   cmd_reg;
    sfa_pkg::sfa_flags_type flags_reg;
    logic [31:0]            accum_reg;
    logic [31:0]            operand_reg;
    logic                   sat_reg;
    logic [TALLY_W-1:0]     tally_reg;
    logic                   ack_reg;
    logic [31:0]            dat_reg;
    logic [31:0]            rd_mux;
    logic [sfa_pkg::ADR_W-1:0] adr_word;
    logic                   reg_wr;
    logic                   cmd_wr;
    logic [1:0]             new_op;
    logic                   exec;
    logic                   is32;
    logic [31:0]            a32;
    logic [31:0]            b32;
    logic [31:0]            diff32;
    logic                   borrow32;
    logic                   ovp32;
    logic                   ovn32;
    logic [31:0]            res32;
    logic [15:0]            half16;
    logic [15:0]            diff16;
    logic                   borrow16;
    logic                   ovp16;
    logic                   ovn16;
    logic                   ov_any;
    logic                   borrow_sel;
    logic [RPT_W-1:0]       rpt_count;
    logic                   rpt_armed;
    logic                   rpt_last;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic op_repeatable(input logic [1:0] op);
        return op == sfa_pkg::OP_UNS16;
    endfunction

    // ==========================================================
    // Bus slave
    assign adr_word = {wb_adr_in[sfa_pkg::ADR_W-1:2], 2'b00};
    // Register writes are refused while an operation runs
    assign reg_wr   = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg && !busy_out;
    assign cmd_wr   = reg_wr && adr_word == sfa_pkg::ADDR_COMMAND && wb_sel_in[0];
    assign new_op   = wb_dat_in[sfa_pkg::CMD_OP_LSB +: 2];

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            ack_reg <= 1'b0;
        end else if (clk_en_in) begin
            ack_reg <= wb_cyc_in && wb_stb_in && !ack_reg;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            dat_reg <= 32'h00000000;
        end else if (clk_en_in && wb_cyc_in && wb_stb_in && !ack_reg) begin
            dat_reg <= rd_mux;
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        case (adr_word)
            sfa_pkg::ADDR_CONTROL: rd_mux[sfa_pkg::SAT_BIT] = sat_reg;
            sfa_pkg::ADDR_COMMAND: begin
                rd_mux[sfa_pkg::CMD_OP_LSB +: 2] = cmd_reg.op;
                rd_mux[sfa_pkg::CMD_HALF_BIT]    = cmd_reg.hi;
                rd_mux[sfa_pkg::BUSY_BIT]        = busy_out;
            end
            sfa_pkg::ADDR_REPEAT: begin
                rd_mux[RPT_W-1:0]             = rpt_count;
                rd_mux[sfa_pkg::ARMED_BIT]    = rpt_armed;
            end
            sfa_pkg::ADDR_ACCUM:   rd_mux = accum_reg;
            sfa_pkg::ADDR_OPERAND: rd_mux = operand_reg;
            sfa_pkg::ADDR_STATUS:  rd_mux[sfa_pkg::FLAG_W-1:0] = flags_reg;
            sfa_pkg::ADDR_TALLY:   rd_mux[TALLY_W-1:0] = tally_reg;
            default:               rd_mux = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sfa_pkg::SFA_IDLE: if (cmd_wr) state_next = sfa_pkg::SFA_EXEC;
            sfa_pkg::SFA_EXEC: if (rpt_last) state_next = sfa_pkg::SFA_IDLE;
            default:           state_next = sfa_pkg::SFA_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_reg <= sfa_pkg::SFA_IDLE;
        end else if (clk_en_in) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cmd_reg <= sfa_pkg::CMD_RST;
        end else if (clk_en_in && cmd_wr) begin
            cmd_reg.op <= new_op;
            cmd_reg.hi <= wb_dat_in[sfa_pkg::CMD_HALF_BIT];
        end
    end

    // Non-repeatable commands drop any pending repeat here
    sfa_repeat_ctl #(
        .CW (RPT_W)
    ) u_repeat (
        .sys_clk_in    (sys_clk_in),
        .srst_in       (srst_in),
        .clk_en_in     (clk_en_in),
        .load_in       (reg_wr && adr_word == sfa_pkg::ADDR_REPEAT && wb_sel_in[0]),
        .load_val_in   (wb_dat_in[RPT_W-1:0]),
        .start_in      (cmd_wr),
        .repeatable_in (op_repeatable(new_op)),
        .step_in       (exec),
        .count_out     (rpt_count),
        .armed_out     (rpt_armed),
        .last_out      (rpt_last)
    );

    // ==========================================================
    // Datapath
    assign exec   = state_reg == sfa_pkg::SFA_EXEC;
    assign is32   = cmd_reg.op != sfa_pkg::OP_REV16;
    assign half16 = cmd_reg.hi ? accum_reg[31:16] : accum_reg[15:0];

    always_comb begin
        unique case (cmd_reg.op)
            sfa_pkg::OP_LONG: begin
                a32 = operand_reg;
                b32 = accum_reg;
            end
            sfa_pkg::OP_REV32: begin
                a32 = accum_reg;
                b32 = operand_reg;
            end
            sfa_pkg::OP_REV16, sfa_pkg::OP_UNS16: begin
                a32 = accum_reg;
                b32 = {16'h0000, operand_reg[15:0]};
            end
        endcase
    end

    sfa_sub_core #(
        .W (32)
    ) u_core32 (
        .a_in       (a32),
        .b_in       (b32),
        .diff_out   (diff32),
        .borrow_out (borrow32),
        .ov_pos_out (ovp32),
        .ov_neg_out (ovn32)
    );

    sfa_sub_core #(
        .W (16)
    ) u_core16 (
        .a_in       (half16),
        .b_in       (operand_reg[15:0]),
        .diff_out   (diff16),
        .borrow_out (borrow16),
        .ov_pos_out (ovp16),
        .ov_neg_out (ovn16)
    );

    // Clamp only in saturating mode
    assign res32 = (sat_reg && ovp32) ? sfa_pkg::MAX_POS_32 :
                   (sat_reg && ovn32) ? sfa_pkg::MAX_NEG_32 : diff32;
    assign ov_any     = is32 ? (ovp32 || ovn32) : (ovp16 || ovn16);
    assign borrow_sel = is32 ? borrow32 : borrow16;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            accum_reg <= sfa_pkg::ACCUM_RST;
        end else if (clk_en_in) begin
            if (exec && cmd_reg.op == sfa_pkg::OP_UNS16) begin
                accum_reg <= res32;
            end else if (reg_wr && adr_word == sfa_pkg::ADDR_ACCUM) begin
                accum_reg <= merge_sel(accum_reg, wb_dat_in, wb_sel_in);
            end
        end
    end

    // Location read and rewritten within one step
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            operand_reg <= sfa_pkg::OPERAND_RST;
        end else if (clk_en_in) begin
            if (exec && cmd_reg.op == sfa_pkg::OP_REV16) begin
                operand_reg[15:0] <= diff16;
            end else if (exec && cmd_reg.op != sfa_pkg::OP_UNS16) begin
                operand_reg <= res32;
            end else if (reg_wr && adr_word == sfa_pkg::ADDR_OPERAND) begin
                operand_reg <= merge_sel(operand_reg, wb_dat_in, wb_sel_in);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            sat_reg <= sfa_pkg::SAT_RST;
        end else if (clk_en_in && reg_wr && adr_word == sfa_pkg::ADDR_CONTROL && wb_sel_in[0]) begin
            sat_reg <= wb_dat_in[sfa_pkg::SAT_BIT];
        end
    end

    // N and Z follow the stored value, C the inverted borrow; overflow is sticky over repeats
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            flags_reg <= sfa_pkg::FLAGS_RST;
        end else if (clk_en_in) begin
            if (exec) begin
                flags_reg.c <= !borrow_sel;
                if (ov_any) begin
                    flags_reg.v <= 1'b1;
                end
                if (is32) begin
                    flags_reg.n <= res32[31];
                    flags_reg.z <= res32 == 32'h00000000;
                end else begin
                    flags_reg.n <= diff16[15];
                    flags_reg.z <= diff16 == 16'h0000;
                end
            end else if (reg_wr && adr_word == sfa_pkg::ADDR_STATUS && wb_sel_in[0]) begin
                flags_reg <= wb_dat_in[sfa_pkg::FLAG_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            tally_reg <= '0;
        end else if (clk_en_in) begin
            if (exec && is32 && !sat_reg && ovp32) begin
                tally_reg <= tally_reg + {{(TALLY_W-1){1'b0}}, 1'b1};
            end else if (exec && is32 && !sat_reg && ovn32) begin
                tally_reg <= tally_reg - {{(TALLY_W-1){1'b0}}, 1'b1};
            end else if (reg_wr && adr_word == sfa_pkg::ADDR_TALLY) begin
                tally_reg <= wb_dat_in[TALLY_W-1:0];
            end
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = dat_reg;
    assign busy_out   = state_reg[1];
    assign result_out = accum_reg;
    assign flags_out  = flags_reg;

    // ==========================================================
    // Checks
    long_sub_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && cmd_reg.op == sfa_pkg::OP_LONG && !sat_reg
        |=> operand_reg == $past(operand_reg) - $past(accum_reg))
        else $error("long subtract result wrong");

    rev16_store_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && cmd_reg.op == sfa_pkg::OP_REV16
        |=> operand_reg[15:0] == $past(half16) - $past(operand_reg[15:0])
            && operand_reg[31:16] == $past(operand_reg[31:16]))
        else $error("reverse 16 result wrong");

    rev16_flags_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && cmd_reg.op == sfa_pkg::OP_REV16
        |=> flags_reg.n == operand_reg[15] && flags_reg.z == (operand_reg[15:0] == 16'h0000))
        else $error("reverse 16 flags wrong");

    rev32_store_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && cmd_reg.op == sfa_pkg::OP_REV32 && !sat_reg
        |=> operand_reg == $past(accum_reg) - $past(operand_reg))
        else $error("reverse 32 result wrong");

    uns16_acc_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && cmd_reg.op == sfa_pkg::OP_UNS16 && !sat_reg
        |=> accum_reg == $past(accum_reg) - {16'h0000, $past(operand_reg[15:0])})
        else $error("unsigned 16 result wrong");

    carry_flag_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec |=> flags_reg.c != $past(borrow_sel))
        else $error("carry flag wrong");

    v_sticky_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && !ov_any |=> $stable(flags_reg.v))
        else $error("overflow flag changed without overflow");

    tally_inc_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && is32 && !sat_reg && ovp32
        |=> tally_reg == $past(tally_reg) + {{(TALLY_W-1){1'b0}}, 1'b1})
        else $error("tally not incremented");

    sat_clamp_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        exec && is32 && sat_reg && ovn32
        |=> (cmd_reg.op == sfa_pkg::OP_UNS16 ? accum_reg : operand_reg) == sfa_pkg::MAX_NEG_32
            && $stable(tally_reg))
        else $error("saturation clamp wrong");

    no_repeat_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        cmd_wr && !op_repeatable(new_op)
        |=> rpt_count == '0 ##1 !busy_out)
        else $error("non-repeatable form repeated");

    repeat_len_a: assert property (
        @(posedge sys_clk_in) disable iff (srst_in || !clk_en_in)
        cmd_wr && op_repeatable(new_op) && rpt_armed && rpt_count == 2
        |=> busy_out [*3] ##1 !busy_out)
        else $error("repeat length wrong");
endmodule

//--- testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Clock, reset and design
    logic                          sys_clk_in;
    logic                          srst_in;
    logic                          clk_en;
    logic                          wb_cyc;
    logic                          wb_stb;
    logic                          wb_we;
    logic [sfa_pkg::ADR_W-1:0]     wb_adr;
    logic [3:0]                    wb_sel;
    logic [31:0]                   wb_wdat;
    logic [31:0]                   wb_rdat;
    logic                          wb_ack;
    logic                          busy;
    logic [31:0]                   result;
    sfa_pkg::sfa_flags_type        flags;
    int                            err_total = 0;
    int                            n_tests = 0;
    int                            cycles = 0;

    sfa_alu uut (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .clk_en_in  (clk_en),
        .wb_cyc_in  (wb_cyc),
        .wb_stb_in  (wb_stb),
        .wb_we_in   (wb_we),
        .wb_adr_in  (wb_adr),
        .wb_sel_in  (wb_sel),
        .wb_dat_in  (wb_wdat),
        .wb_dat_out (wb_rdat),
        .wb_ack_out (wb_ack),
        .busy_out   (busy),
        .result_out (result),
        .flags_out  (flags)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            results();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic results();
        if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Idle edge first, so cyc and stb stay low one cycle between requests
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_sel <= 4'hF;
        wb_adr <= a;
        wb_wdat <= d;
        do @(posedge sys_clk_in); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        wb(1'b0, a, 32'h00000000, q);
        chk(name, exp, q);
    endtask

    // Counts cycles with busy high after the command commits
    task automatic run(input logic [31:0] cmd, input int steps);
        int n;
        n = 0;
        wr(sfa_pkg::ADDR_COMMAND, cmd);
        #1;
        while (busy === 1'b1 && n < 40) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk("busy_cycles", steps, n);
    endtask

    task automatic setup(input logic sat, input logic [31:0] acc, input logic [31:0] opnd, input logic [3:0] st);
        wr(sfa_pkg::ADDR_CONTROL, {31'h0, sat});
        wr(sfa_pkg::ADDR_ACCUM, acc);
        wr(sfa_pkg::ADDR_OPERAND, opnd);
        wr(sfa_pkg::ADDR_STATUS, {28'h0, st});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rchk(sfa_pkg::ADDR_ACCUM, 32'h00000000, "accum_rst");
        rchk(sfa_pkg::ADDR_STATUS, 32'h00000000, "status_rst");
        rchk(sfa_pkg::ADDR_TALLY, 32'h00000000, "tally_rst");
        rchk(8'h1C, 32'h00000000, "unmapped");
    endtask

    // Armed repeat ahead of a non-repeatable form, sticky V kept
    task automatic t_long();
        setup(1'b0, 32'h00000007, 32'h00000005, 4'h8);
        wr(sfa_pkg::ADDR_REPEAT, 32'h00000004);
        run(32'h00000000, 1);
        rchk(sfa_pkg::ADDR_OPERAND, 32'hFFFFFFFE, "long_mem");
        rchk(sfa_pkg::ADDR_STATUS, 32'h0000000A, "long_flags");
        rchk(sfa_pkg::ADDR_REPEAT, 32'h00000000, "long_rpt");
        chk("result_out", 32'h00000007, result);
    endtask

    task automatic t_rev16();
        setup(1'b0, 32'h80000005, 32'hABCD0001, 4'h0);
        run(32'h00000011, 1);
        rchk(sfa_pkg::ADDR_OPERAND, 32'hABCD7FFF, "rev16_hi");
        rchk(sfa_pkg::ADDR_STATUS, 32'h0000000C, "rev16_ov");
        wr(sfa_pkg::ADDR_OPERAND, 32'h00000005);
        run(32'h00000001, 1);
        rchk(sfa_pkg::ADDR_OPERAND, 32'h00000000, "rev16_lo");
        rchk(sfa_pkg::ADDR_STATUS, 32'h0000000D, "rev16_zero");
        wr(sfa_pkg::ADDR_OPERAND, 32'h00000006);
        run(32'h00000001, 1);
        rchk(sfa_pkg::ADDR_OPERAND, 32'h0000FFFF, "rev16_neg");
        rchk(sfa_pkg::ADDR_STATUS, 32'h0000000A, "rev16_nflag");
    endtask

    task automatic t_rev32_sat();
        setup(1'b1, 32'h80000000, 32'h00000001, 4'h0);
        wr(sfa_pkg::ADDR_TALLY, 32'h00000000);
        run(32'h00000002, 1);
        rchk(sfa_pkg::ADDR_OPERAND, 32'h80000000, "rev32_sat");
        rchk(sfa_pkg::ADDR_STATUS, 32'h0000000E, "rev32_flags");
        rchk(sfa_pkg::ADDR_TALLY, 32'h00000000, "rev32_tally");
        setup(1'b1, 32'hFFFFFFFF, 32'h7FFFFFFF, 4'h0);
        run(32'h00000000, 1);
        rchk(sfa_pkg::ADDR_OPERAND, 32'h7FFFFFFF, "long_sat");
        rchk(sfa_pkg::ADDR_STATUS, 32'h00000008, "long_sat_flags");
    endtask

    // Three steps, only the first overflows downward
    task automatic t_uns16_rpt();
        setup(1'b0, 32'h80000002, 32'hFFFF0003, 4'h0);
        wr(sfa_pkg::ADDR_TALLY, 32'h00000000);
        wr(sfa_pkg::ADDR_REPEAT, 32'h00000002);
        run(32'h00000003, 3);
        rchk(sfa_pkg::ADDR_ACCUM, 32'h7FFFFFF9, "uns16_acc");
        chk("result_out", 32'h7FFFFFF9, result);
        rchk(sfa_pkg::ADDR_STATUS, 32'h0000000C, "uns16_flags");
        rchk(sfa_pkg::ADDR_TALLY, 32'h000000FF, "uns16_tally");
        setup(1'b0, 32'hFFFFFFFF, 32'h7FFFFFFF, 4'h0);
        run(32'h00000000, 1);
        rchk(sfa_pkg::ADDR_OPERAND, 32'h80000000, "long_pos_ov");
        rchk(sfa_pkg::ADDR_TALLY, 32'h00000000, "tally_up");
    endtask

    task automatic t_uns16_flags();
        setup(1'b0, 32'h00000003, 32'h00000003, 4'h8);
        run(32'h00000003, 1);
        rchk(sfa_pkg::ADDR_STATUS, 32'h0000000D, "uns16_zero");
        wr(sfa_pkg::ADDR_OPERAND, 32'h00000001);
        run(32'h00000003, 1);
        chk("result_out", 32'hFFFFFFFF, result);
        chk("flags_out", 32'h0000000A, {28'h0, flags});
    endtask

    // Low enable must hold the pending step and the accumulator
    task automatic t_freeze();
        setup(1'b0, 32'h00000010, 32'h00000005, 4'h0);
        wr(sfa_pkg::ADDR_COMMAND, 32'h00000003);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        #1;
        chk("frozen_busy", 32'h00000001, {31'h0, busy});
        chk("frozen_acc", 32'h00000010, result);
        @(posedge sys_clk_in);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk("thawed_busy", 32'h00000000, {31'h0, busy});
        chk("thawed_acc", 32'h0000000B, result);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        srst_in = 1'b1;
        clk_en = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_wdat = 32'h00000000;
        repeat (12) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_long();
        t_rev16();
        t_rev32_sat();
        t_uns16_rpt();
        t_uns16_flags();
        t_freeze();
        results();
    end
endmodule
